// file: core/cid_consts.vh
/*
 * Constants of the control and indirect-operation decoder: register offsets,
 * status bit positions, reset values, opcode patterns and cycle counts.
 * Assumes inclusion by bare name from the decoder's design files.
 */
`ifndef CID_CONSTS_VH
`define CID_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CID_REG_INSTR   8'h00
`define CID_REG_ACC     8'h04
`define CID_REG_STATUS  8'h08
`define CID_REG_PTR     8'h0C
`define CID_REG_PTR0    8'h10
`define CID_REG_PTR1    8'h14
`define CID_REG_DIR     8'h18
`define CID_REG_CYCLES  8'h1C

// ****************************************************************
// Status bit positions
// ****************************************************************
`define CID_ST_C        0
`define CID_ST_DC       1
`define CID_ST_Z        2
`define CID_ST_SLP      3
`define CID_ST_EXP      4
`define CID_ST_BUSY     8
`define CID_ST_SLEEP    9

// ****************************************************************
// Reset values
// ****************************************************************
`define CID_RST_ACC     8'h00
`define CID_RST_IP      15'h0000
`define CID_RST_PTR     16'h0000
`define CID_RST_DIR     8'hFF

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define CID_OP_RELJMP   14'b11_001?_????_????
`define CID_OP_ACCJMP   14'b00_0000_0000_1011
`define CID_OP_CALL     14'b10_0???_????_????
`define CID_OP_ACCCALL  14'b00_0000_0000_1010
`define CID_OP_ABSJMP   14'b10_1???_????_????
`define CID_OP_INTRET   14'b00_0000_0000_1001
`define CID_OP_LITRET   14'b11_0100_????_????
`define CID_OP_RETURN   14'b00_0000_0000_1000
`define CID_OP_WDTKICK  14'b00_0000_0110_0100
`define CID_OP_IDLE     14'b00_0000_0000_0000
`define CID_OP_RESTART  14'b00_0000_0000_0001
`define CID_OP_SLEEP    14'b00_0000_0110_0011
`define CID_OP_DIRLOAD  14'b00_0000_0110_0???
`define CID_OP_PTRADD   14'b11_0001_0???_????
`define CID_OP_ILOAD    14'b00_0000_0001_0???
`define CID_OP_ILOADX   14'b11_1111_0???_????
`define CID_OP_ISTORE   14'b00_0000_0001_1???
`define CID_OP_ISTOREX  14'b11_1111_1???_????
`define CID_OP_ANDLIT   14'b11_1001_????_????
`define CID_OP_ADDLIT   14'b11_1110_????_????
`define CID_OP_ANDFILE  14'b00_0101_????_????

// ****************************************************************
// Instruction cycle counts
// ****************************************************************
`define CID_CYC_ONE     2'h1
`define CID_CYC_TWO     2'h2

`endif

// file: core/cid_alu.v
/*
 * Arithmetic helper of the decoder: accumulator AND / ADD with status flags,
 * and the 16-bit pointer adder. Purely combinational.
 * Assumes the caller selects operands and decides which flags to keep.
 */
module cid_alu
(
  // Accumulator operands
  input  wire [7:0]  acc_a,
  input  wire [7:0]  acc_b,
  input  wire        do_add,
  // Pointer operands
  input  wire [15:0] ptr_a,
  input  wire [15:0] ptr_b,
  // Results
  output wire [7:0]  acc_res,
  output wire        carry,
  output wire        half_byte_overflow_bit,
  output wire        zero,
  output wire [15:0] ptr_res
);

  wire [8:0] sum9;
  wire [4:0] sum5;

  // Byte and low-nibble sums
  assign sum9 = {1'b0, acc_a} + {1'b0, acc_b};
  assign sum5 = {1'b0, acc_a[3:0]} + {1'b0, acc_b[3:0]};

  // Result and flags
  assign acc_res                = do_add ? sum9[7:0] : (acc_a & acc_b);
  assign carry                  = sum9[8];
  assign half_byte_overflow_bit = sum5[4];
  assign zero                   = (acc_res == 8'h00);

  // Pointer add wraps modulo 16 bits
  assign ptr_res = ptr_a + ptr_b;

endmodule // cid_alu

// file: core/cid_decoder.v
/*
 * Control and indirect-operation decoder with an AHB-Lite register slave.
 * Software writes a 14-bit instruction word; the block executes it against
 * its accumulator, flags, instruction pointer, stack, pointer pairs, a
 * 128-byte data store and eight pin-direction registers.
 * Assumes single-word AHB-Lite transfers and a synchronous active-low reset.
 */
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`include "cid_consts.vh"

module cid_decoder
#(
  parameter STACK_DEPTH = 16,
  parameter MEM_WORDS   = 128
)
(
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Device-side outputs
  output reg  [63:0] pin_dir,
  output reg         sleeping,
  output reg         watchdog_kick,
  output reg         soft_restart
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg  [13:0] instr;
  reg  [7:0]  acc;
  reg         st_c;
  reg         st_dc;
  reg         st_z;
  reg         tmr_expiry_status;
  reg         sleep_entered_flag;
  reg  [14:0] instruction_pointer;
  reg  [15:0] ptr0;
  reg  [15:0] ptr1;
  reg  [1:0]  busy_cnt;
  reg  [1:0]  last_cycles;
  reg  [3:0]  sp;
  reg  [14:0] stack [0:STACK_DEPTH-1];
  reg  [7:0]  mem [0:MEM_WORDS-1];
  reg         dp_write;
  reg  [7:0]  dp_addr;
  reg         exec;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  wire        addr_ok;
  wire        issue;
  wire        busy;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign busy      = (busy_cnt != 2'h0);
  assign addr_ok   = hsel & hready & htrans[1];
  assign issue     = dp_write & (dp_addr == `CID_REG_INSTR) & ~busy;

  // Pointer-pair select by one instruction bit
  function [15:0] pick_ptr;
    input       sel;
    input [15:0] p0;
    input [15:0] p1;
    begin
      pick_ptr = sel ? p1 : p0;
    end
  endfunction

  // ****************************************************************
  // Execution datapath
  // ****************************************************************
  reg  [7:0]  alu_b;
  reg         alu_add;
  reg  [15:0] ptr_b;
  reg         ptr_n;
  wire [15:0] ptr_cur;
  wire [7:0]  alu_res;
  wire        alu_c;
  wire        alu_dc;
  wire        alu_z;
  wire [15:0] ptr_sum;
  wire [14:0] ip_next;

  assign ptr_cur = pick_ptr(ptr_n, ptr0, ptr1);
  assign ip_next = instruction_pointer + 15'h0001;

  cid_alu u_alu
  (
    .acc_a                  (acc),
    .acc_b                  (alu_b),
    .do_add                 (alu_add),
    .ptr_a                  (ptr_cur),
    .ptr_b                  (ptr_b),
    .acc_res                (alu_res),
    .carry                  (alu_c),
    .half_byte_overflow_bit (alu_dc),
    .zero                   (alu_z),
    .ptr_res                (ptr_sum)
  );

  reg  [7:0]  next_acc;
  reg         next_c;
  reg         next_dc;
  reg         next_z;
  reg         next_to;
  reg         next_pd;
  reg  [14:0] next_ip;
  reg  [15:0] next_ptr;
  reg         ptr_we;
  reg  [15:0] eff_addr;
  reg         mem_we;
  reg  [6:0]  mem_addr;
  reg  [7:0]  mem_wdata;
  reg         push;
  reg         pop;
  reg         dir_we;
  reg         ind_access;
  reg  [1:0]  base_cyc;
  reg         do_sleep;
  reg         do_kick;
  reg         do_restart;

  // Operand selection for the adders
  always @*
  begin
    alu_b   = instr[7:0];
    alu_add = 1'b0;
    ptr_n   = instr[2];
    ptr_b   = {16{instr[0]}} | 16'h0001; // Modifier bit 0 picks decrement
    casez (instr)
      `CID_OP_ADDLIT:  alu_add = 1'b1;
      `CID_OP_ANDFILE: alu_b = mem[instr[6:0]];
      `CID_OP_PTRADD, `CID_OP_ILOADX, `CID_OP_ISTOREX:
      begin
        ptr_n = instr[6];
        ptr_b = {{10{instr[5]}}, instr[5:0]};
      end
      default:         alu_add = 1'b0;
    endcase
  end

  // Instruction decode and next state
  always @*
  begin
    next_acc   = acc;
    next_c     = st_c;
    next_dc    = st_dc;
    next_z     = st_z;
    next_to    = tmr_expiry_status;
    next_pd    = sleep_entered_flag;
    next_ip    = ip_next;
    next_ptr   = ptr_sum;
    ptr_we     = 1'b0;
    eff_addr   = instr[1] ? ptr_cur : ptr_sum;
    mem_we     = 1'b0;
    mem_addr   = instr[6:0];
    mem_wdata  = acc;
    push       = 1'b0;
    pop        = 1'b0;
    dir_we     = 1'b0;
    ind_access = 1'b0;
    base_cyc   = `CID_CYC_ONE;
    do_sleep   = 1'b0;
    do_kick    = 1'b0;
    do_restart = 1'b0;
    casez (instr)
      `CID_OP_RELJMP:
      begin
        next_ip  = ip_next + {{6{instr[8]}}, instr[8:0]};
        base_cyc = `CID_CYC_TWO;
      end
      `CID_OP_ACCJMP:
      begin
        next_ip  = ip_next + {7'h00, acc};
        base_cyc = `CID_CYC_TWO;
      end
      `CID_OP_CALL:
      begin
        push     = 1'b1;
        next_ip  = {instruction_pointer[14:11], instr[10:0]};
        base_cyc = `CID_CYC_TWO;
      end
      `CID_OP_ACCCALL:
      begin
        push     = 1'b1;
        next_ip  = {instruction_pointer[14:8], acc};
        base_cyc = `CID_CYC_TWO;
      end
      `CID_OP_ABSJMP:
      begin
        next_ip  = {instruction_pointer[14:11], instr[10:0]};
        base_cyc = `CID_CYC_TWO;
      end
      `CID_OP_INTRET, `CID_OP_RETURN:
      begin
        pop      = 1'b1;
        next_ip  = stack[sp - 4'h1];
        base_cyc = `CID_CYC_TWO;
      end
      `CID_OP_LITRET:
      begin
        pop      = 1'b1;
        next_ip  = stack[sp - 4'h1];
        next_acc = instr[7:0];
        base_cyc = `CID_CYC_TWO;
      end
      `CID_OP_WDTKICK:
      begin
        do_kick = 1'b1;
        next_to = 1'b1;
        next_pd = 1'b1;
      end
      `CID_OP_SLEEP:
      begin
        do_sleep = 1'b1;
        next_to  = 1'b1;
        next_pd  = 1'b0;
      end
      `CID_OP_RESTART: do_restart = 1'b1;
      `CID_OP_IDLE:    base_cyc = `CID_CYC_ONE;
      `CID_OP_DIRLOAD: dir_we = 1'b1;
      `CID_OP_PTRADD:  ptr_we = 1'b1;
      `CID_OP_ILOAD:
      begin
        ptr_we     = 1'b1;
        ind_access = 1'b1;
        mem_addr   = eff_addr[6:0];
        next_acc   = mem[eff_addr[6:0]];
        next_z     = (mem[eff_addr[6:0]] == 8'h00);
      end
      `CID_OP_ISTORE:
      begin
        ptr_we     = 1'b1;
        ind_access = 1'b1;
        mem_we     = 1'b1;
        mem_addr   = eff_addr[6:0];
      end
      `CID_OP_ILOADX:
      begin
        ind_access = 1'b1;
        eff_addr   = ptr_sum;
        next_acc   = mem[ptr_sum[6:0]];
        next_z     = (mem[ptr_sum[6:0]] == 8'h00);
      end
      `CID_OP_ISTOREX:
      begin
        ind_access = 1'b1;
        eff_addr   = ptr_sum;
        mem_we     = 1'b1;
        mem_addr   = ptr_sum[6:0];
      end
      `CID_OP_ANDLIT:
      begin
        next_acc = alu_res;
        next_z   = alu_z;
      end
      `CID_OP_ADDLIT:
      begin
        next_acc = alu_res;
        next_c   = alu_c;
        next_dc  = alu_dc;
        next_z   = alu_z;
      end
      `CID_OP_ANDFILE:
      begin
        next_z    = alu_z;
        mem_we    = instr[7];
        mem_wdata = alu_res;
        if (!instr[7])
          next_acc = alu_res;
      end
      default:         base_cyc = `CID_CYC_ONE;
    endcase
  end

  // ****************************************************************
  // Sequential update
  // ****************************************************************
  wire [1:0] total_cyc;
  assign total_cyc = base_cyc + {1'b0, ind_access & eff_addr[15]};

  // Bus address phase capture and read data
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end
    else
    begin
      dp_write <= addr_ok & hwrite;
      dp_addr  <= haddr[7:0];
      if (addr_ok & ~hwrite)
      begin
        case (haddr[7:0])
          `CID_REG_INSTR:  hrdata <= {18'h00000, instr};
          `CID_REG_ACC:    hrdata <= {24'h000000, acc};
          `CID_REG_STATUS: hrdata <= {22'h000000, sleeping, busy, 3'h0, tmr_expiry_status,
                                      sleep_entered_flag, st_z, st_dc, st_c};
          `CID_REG_PTR:    hrdata <= {17'h00000, instruction_pointer};
          `CID_REG_PTR0:   hrdata <= {16'h0000, ptr0};
          `CID_REG_PTR1:   hrdata <= {16'h0000, ptr1};
          `CID_REG_DIR:    hrdata <= pin_dir[31:0];
          `CID_REG_CYCLES: hrdata <= {26'h0000000, sp, last_cycles};
          default:         hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Architectural state: bus writes or instruction execution
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      instr               <= 14'h0000;
      acc                 <= `CID_RST_ACC;
      st_c                <= 1'b0;
      st_dc               <= 1'b0;
      st_z                <= 1'b0;
      tmr_expiry_status   <= 1'b1;
      sleep_entered_flag  <= 1'b1;
      instruction_pointer <= `CID_RST_IP;
      ptr0                <= `CID_RST_PTR;
      ptr1                <= `CID_RST_PTR;
      busy_cnt            <= 2'h0;
      last_cycles         <= 2'h0;
      sp                  <= 4'h0;
      pin_dir             <= {8{`CID_RST_DIR}};
      sleeping            <= 1'b0;
      watchdog_kick       <= 1'b0;
      soft_restart        <= 1'b0;
    end
    else
    begin
      watchdog_kick <= 1'b0;
      soft_restart  <= 1'b0;
      if (busy)
        busy_cnt <= busy_cnt - 2'h1;
      if (issue)
      begin
        instr    <= hwdata[13:0];
        sleeping <= 1'b0;
      end
      else if (dp_write)
      begin
        case (dp_addr)
          `CID_REG_ACC:    acc <= hwdata[7:0];
          `CID_REG_STATUS:
          begin
            st_c  <= hwdata[`CID_ST_C];
            st_dc <= hwdata[`CID_ST_DC];
            st_z  <= hwdata[`CID_ST_Z];
          end
          `CID_REG_PTR:    instruction_pointer <= hwdata[14:0];
          `CID_REG_PTR0:   ptr0 <= hwdata[15:0];
          `CID_REG_PTR1:   ptr1 <= hwdata[15:0];
          default:         acc <= acc;
        endcase
      end
      // Execute the word captured on the previous issue
      if (exec)
      begin
        acc                 <= next_acc;
        st_c                <= next_c;
        st_dc               <= next_dc;
        st_z                <= next_z;
        tmr_expiry_status   <= next_to;
        sleep_entered_flag  <= next_pd;
        instruction_pointer <= do_restart ? `CID_RST_IP : next_ip;
        busy_cnt            <= total_cyc - 2'h1;
        last_cycles         <= total_cyc;
        sleeping            <= do_sleep;
        watchdog_kick       <= do_kick;
        soft_restart        <= do_restart;
        if (ptr_we & ~ptr_n)
          ptr0 <= next_ptr;
        if (ptr_we & ptr_n)
          ptr1 <= next_ptr;
        if (push)
          sp <= sp + 4'h1;
        if (pop)
          sp <= sp - 4'h1;
        if (dir_we)
          pin_dir[instr[2:0]*8 +: 8] <= acc;
      end
    end
  end

  // One-cycle execute strobe following an accepted issue
  always @(posedge mclk)
  begin
    if (!rst_n)
      exec <= 1'b0;
    else
      exec <= issue;
  end

  // Stack and data store writes
  always @(posedge mclk)
  begin
    if (exec & push)
      stack[sp] <= ip_next;
    if (exec & mem_we)
      mem[mem_addr] <= mem_wdata;
  end

endmodule // cid_decoder

// file: verification/cid_decoder_props.sv
/* Checker of the decoder's device-side outputs against issued instruction words.
   Assumes zero-wait AHB-Lite writes of the instruction register at byte 0. */
module cid_decoder_chk
(
  // Clock and reset
  input wire        mclk,
  input wire        rst_n,
  // Bus side
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  // Device side
  input wire [63:0] pin_dir,
  input wire        sleeping,
  input wire        watchdog_kick,
  input wire        soft_restart
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Issue tracking
  // ****************************************************************
  reg        ap_q;
  reg        v_q;
  reg [13:0] op_q;
  wire       sl_hit = v_q && op_q == 14'h0063;
  wire       kk_hit = v_q && op_q == 14'h0064;
  wire       rs_hit = v_q && op_q == 14'h0001;
  wire       dl_hit = v_q && op_q[13:3] == 11'h00C;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Address phase, then the word of the data phase
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ap_q <= 1'b0;
      v_q  <= 1'b0;
    end
    else
    begin
      ap_q <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
      v_q  <= ap_q && hready;
    end
    op_q <= hwdata[13:0];
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  a_sleep_enter: assert property (sl_hit |=> sleeping)
    else $error("sleep word did not raise sleeping");
  a_sleep_cause: assert property ($rose(sleeping) |-> $past(sl_hit))
    else $error("sleeping rose without a sleep word");
  a_kick_pulse: assert property (kk_hit |=> watchdog_kick ##1 !watchdog_kick)
    else $error("watchdog kick not a single pulse");
  a_kick_cause: assert property (watchdog_kick |-> $past(kk_hit))
    else $error("watchdog kick without its word");
  a_restart_pulse: assert property (rs_hit |=> soft_restart ##1 !soft_restart)
    else $error("restart not a single pulse");
  a_restart_cause: assert property (soft_restart |-> $past(rs_hit))
    else $error("restart without its word");
  a_dir_hold: assert property (!dl_hit |=> $stable(pin_dir))
    else $error("pin direction changed without a load");
  a_dir_one_byte: assert property (dl_hit |=> ((pin_dir ^ $past(pin_dir))
    & ~(64'hFF << {$past(op_q[2:0]), 3'b000})) == 64'h0)
    else $error("pin direction load touched another byte");
endmodule // cid_decoder_chk

bind cid_decoder cid_decoder_chk u_chk
(
  .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .pin_dir, .sleeping, .watchdog_kick, .soft_restart
);

// file: verification/tb_top.sv
/* Self-checking bench of the decoder, one task a scenario over AHB-Lite.
   Assumes the zero-wait slave and register map of the decoder. */
`include "cid_consts.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam logic [7:0] ACC = `CID_REG_ACC;
  localparam logic [7:0] STS = `CID_REG_STATUS;
  localparam logic [7:0] IP  = `CID_REG_PTR;
  localparam logic [7:0] P0  = `CID_REG_PTR0;
  localparam logic [7:0] P1  = `CID_REG_PTR1;
  localparam logic [7:0] CYC = `CID_REG_CYCLES;
  logic        mclk   = 1'b0;
  logic        rst_n  = 1'b0;
  logic        hsel   = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize  = 3'h2;
  logic [31:0] haddr  = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic [63:0] pin_dir;
  logic        hreadyout, hresp, sleeping, watchdog_kick, soft_restart;
  wire         hready = hreadyout;
  int          err_total = 0;
  int          num_checks = 0;
  int          kicks = 0;
  int          restarts = 0;

  cid_decoder DUT
  (
    .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .pin_dir, .sleeping, .watchdog_kick, .soft_restart
  );

  // Clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  // Pulse counters
  always @(posedge mclk)
  begin
    if (watchdog_kick === 1'b1) kicks++;
    if (soft_restart === 1'b1) restarts++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Counts and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Counted give-up on a hang
  task automatic stuck();
    err_total++;
    complete_run();
  endtask

  // One compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do
      @(posedge mclk);
    while (hready !== 1'b1 && ++n < 40);
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge mclk);
    while (hready !== 1'b1 && ++n < 40);
    rv = hrdata;
    if (n >= 40)
      stuck();
  endtask

  // Read one register and compare under a mask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rv & m);
  endtask

  // Issue one word, wait two cycles, then poll busy
  task automatic exe(input logic [13:0] op);
    int n = 0;
    bus(1'b1, `CID_REG_INSTR, {18'h0, op});
    repeat (2) @(posedge mclk);
    do
      bus(1'b0, STS, 32'h0);
    while (rv[`CID_ST_BUSY] !== 1'b0 && ++n < 20);
    if (n >= 20)
      stuck();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset state and unmapped read
  task automatic t_reset();
    rc("status", STS, 32'h31F, 32'h018);
    rc("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("pin_dir", 32'hFFFFFFFF, pin_dir[63:32]);
    $display("test reset done");
  endtask

  // Literal AND and add, flag by flag
  task automatic t_lit();
    bus(1'b1, STS, 32'h3);
    bus(1'b1, ACC, 32'hF0);
    exe(14'h390F);
    rc("and_flags", STS, 32'h1F, 32'h1F);
    bus(1'b1, STS, 32'h0);
    bus(1'b1, ACC, 32'h8F);
    exe(14'h3E71);
    rc("add_flags", STS, 32'h1F, 32'h1F);
    exe(14'h3E01);
    exe(14'h3E0F);
    rc("add_acc", ACC, 32'hFF, 32'h10);
    rc("add_half", STS, 32'h1F, 32'h1A);
    $display("test literal done");
  endtask

  // Pointer offsets at both ends of the range
  task automatic t_ptr();
    bus(1'b1, STS, 32'h5);
    bus(1'b1, P0, 32'hFFFE);
    exe(14'h3105);
    rc("ptr0_wrap", P0, 32'hFFFF, 32'h0003);
    bus(1'b1, P1, 32'h0002);
    exe(14'h3160);
    rc("ptr1_neg", P1, 32'hFFFF, 32'hFFE2);
    exe(14'h315F);
    rc("ptr1_pos", P1, 32'hFFFF, 32'h0001);
    rc("ptr_flags", STS, 32'h1F, 32'h1D);
    $display("test pointer done");
  endtask

  // Indirect loads and stores, every modifier, far pointer
  task automatic t_ind();
    bus(1'b1, STS, 32'h4);
    bus(1'b1, ACC, 32'h5A);
    bus(1'b1, P0, 32'h0010);
    exe(14'h001A);
    rc("st_post_inc", P0, 32'hFFFF, 32'h0011);
    rc("st_flags", STS, 32'h1F, 32'h1C);
    bus(1'b1, ACC, 32'h0);
    exe(14'h0011);
    rc("ld_pre_dec", P0, 32'hFFFF, 32'h0010);
    rc("ld_acc", ACC, 32'hFF, 32'h5A);
    rc("ld_cycles", CYC, 32'h3, 32'h1);
    bus(1'b1, P1, 32'h0008);
    bus(1'b1, ACC, 32'h0);
    exe(14'h3FC9);
    exe(14'h3F48);
    rc("ldx_acc", ACC, 32'hFF, 32'h5A);
    exe(14'h3F49);
    rc("stx_ldx", STS, 32'h1F, 32'h1C);
    bus(1'b1, P1, 32'h0012);
    exe(14'h001F);
    rc("st_post_dec", P1, 32'hFFFF, 32'h0011);
    bus(1'b1, P0, 32'h7FFF);
    exe(14'h0010);
    rc("pre_inc", P0, 32'hFFFF, 32'h8000);
    rc("far_cycles", CYC, 32'h3, 32'h2);
    $display("test indirect done");
  endtask

  // File AND to the file and to the accumulator
  task automatic t_fand();
    bus(1'b1, P0, 32'h0020);
    bus(1'b1, ACC, 32'hCC);
    exe(14'h3F80);
    bus(1'b1, ACC, 32'h0F);
    exe(14'h05A0);
    exe(14'h3F00);
    rc("fand_file", ACC, 32'hFF, 32'h0C);
    bus(1'b1, STS, 32'h3);
    bus(1'b1, ACC, 32'h30);
    exe(14'h0520);
    rc("fand_flags", STS, 32'h1F, 32'h1F);
    $display("test file and done");
  endtask

  // Jumps, calls and returns from a table
  task automatic t_ctrl();
    logic [13:0] ops [10] = '{14'h3203, 14'h000B, 14'h000A, 14'h3477, 14'h2855,
                              14'h2200, 14'h0008, 14'h2300, 14'h0009, 14'h33FE};
    logic [14:0] ips [10] = '{15'h104, 15'h10A, 15'h120, 15'h10B, 15'h055,
                              15'h200, 15'h056, 15'h300, 15'h057, 15'h056};
    logic [7:0]  acc [10] = '{8'h11, 8'h05, 8'h20, 8'h11, 8'h11,
                              8'h11, 8'h11, 8'h11, 8'h11, 8'h11};
    bus(1'b1, IP, 32'h100);
    for (int i = 0; i < 10; i++)
    begin
      bus(1'b1, ACC, {24'h0, acc[i]});
      exe(ops[i]);
      rc("ip", IP, 32'h7FFF, {17'h0, ips[i]});
      rc("cycles", CYC, 32'h3, 32'h2);
      rc("acc", ACC, 32'hFF, (i == 3) ? 32'h77 : {24'h0, acc[i]});
    end
    $display("test control done");
  endtask

  // Direction loads, sleep, kick, idle, restart
  task automatic t_inh();
    int k0 = kicks;
    int r0 = restarts;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, ACC, 32'h10 + 32'(i));
      exe(14'h0060 + 14'(i));
    end
    // Words 0063 and 0064 are sleep and kick, so bytes 3 and 4 keep FF
    chk("dir_hi", 32'h171615FF, pin_dir[63:32]);
    chk("dir_lo", 32'hFF121110, pin_dir[31:0]);
    exe(14'h0063);
    rc("sleep", STS, 32'h218, 32'h210);
    exe(14'h0064);
    // Second kick of this test, the first came from the loop
    chk("kick", 32'(k0 + 2), 32'(kicks));
    rc("kick_flags", STS, 32'h218, 32'h018);
    bus(1'b1, IP, 32'h0040);
    exe(14'h0000);
    rc("idle_ip", IP, 32'h7FFF, 32'h0041);
    exe(14'h0001);
    chk("restart", 32'(r0 + 1), 32'(restarts));
    rc("restart_ip", IP, 32'h7FFF, 32'h0);
    $display("test inherent done");
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_lit();
    t_ptr();
    t_ind();
    t_fand();
    t_ctrl();
    t_inh();
    complete_run();
  end
endmodule // tb_top
